// file: design/bom_monitor.sv
// Function
// - Overcurrent DAC code from 4-bit field
// - One bit selects debounce or blanking
// - Debounce: time comparator while low-side on
// - Blanking: ignore comparator after low-side turn-on
// - Qualifying time is code times 500 ns
// - Overcurrent only sets sticky phase flag
// - On-state and off-state from gate drives
// - On-state check needs enable and on-state
// - Open-load DAC code from 4-bit field
// - Undercurrent timer sets open-load after 100 ms
// - Current above threshold clears fault, flag stays
// - Off-state check needs disable low, all off
// - Off-state drives terminal sink and source
// - One bit picks 100 or 400 uA
// - High terminal difference for 100 ms flags
// - Leaving off-state resets timer silently
// - Off-state fault clears, flag stays set
`timescale 1ns/1ps
`default_nettype none
module bom_monitor #(
  parameter int unsigned OPEN_TICK_CYCLES = bom_pkg::OPEN_TICK_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire bom_pkg::bom_gates_t gates,
  input  wire logic              oc_cmp_a,
  input  wire logic              oc_cmp_b,
  input  wire logic              sense_below_thr,
  input  wire logic              terminal_diff_high,
  output logic      [3:0]        overcurrent_threshold_code,
  output logic      [3:0]        open_load_threshold_code,
  output logic                   sink_enable,
  output logic                   source_enable,
  output logic                   test_current_select,
  output logic                   irq
);
  import bom_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
    end
    else if (ce)
    begin
      pin_meta_ff <= {terminal_diff_high, sense_below_thr, oc_cmp_b, oc_cmp_a};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  logic [1:0] oc_cmp;
  logic       below_s;
  logic       diff_s;
  assign oc_cmp  = pin_sync_ff[1:0];
  assign below_s = pin_sync_ff[2];
  assign diff_s  = pin_sync_ff[3];

  // ****************************************
  // Prescalers
  // ****************************************
  logic qual_tick;
  logic open_tick;

  bom_tick #(.CYCLES(QUAL_STEP_CYC)) u_qual_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tick    (qual_tick)
  );

  bom_tick #(.CYCLES(OPEN_TICK_CYCLES)) u_open_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tick    (open_tick)
  );

  // ****************************************
  // Configuration
  // ****************************************
  bom_cfg_t   cfg_ff;
  bom_flags_t status_ff;
  bom_flags_t mask_ff;
  logic       wr_cfg;
  logic       wr_status;
  logic       wr_mask;

  assign wr_cfg    = reg_wr && (reg_addr == ADDR_CONFIG);
  assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
  assign wr_mask   = reg_wr && (reg_addr == ADDR_MASK);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_ff <= CONFIG_RST;
    else if (ce && wr_cfg)
      cfg_ff <= bom_cfg_t'(reg_wdata[15:0]);
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      mask_ff <= MASK_RST;
    else if (ce && wr_mask)
      mask_ff <= bom_flags_t'(reg_wdata[2:0]);
  end

  // ****************************************
  // Bridge state decode
  // ****************************************
  logic on_state;
  logic off_state;
  logic on_active;
  logic off_active;
  logic [1:0] low_on;

  assign on_state   = (gates.gate_high_a && gates.gate_low_b) ||
                      (gates.gate_high_b && gates.gate_low_a);
  assign off_state  = !(gates.gate_high_a || gates.gate_low_a ||
                        gates.gate_high_b || gates.gate_low_b);
  assign on_active  = cfg_ff.onstate_check_enable && on_state;
  assign off_active = !cfg_ff.offstate_check_disable && off_state;
  assign low_on     = {gates.gate_low_b, gates.gate_low_a};

  // ****************************************
  // Overcurrent qualifiers
  // ****************************************
  logic [1:0] oc_evt;

  for (genvar ph = 0; ph < 2; ph++)
  begin : g_phase
    logic [3:0] qual_cnt_ff;
    logic       low_prev_ff;
    logic       blank_busy;

    assign blank_busy = (qual_cnt_ff != 4'h0);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        qual_cnt_ff <= 4'h0;
        low_prev_ff <= 1'b0;
      end
      else if (ce)
      begin
        low_prev_ff <= low_on[ph];
        if (cfg_ff.overcurrent_filter_mode == MODE_DEBOUNCE)
        begin
          if (!(oc_cmp[ph] && low_on[ph]))
            qual_cnt_ff <= 4'h0;
          else if (qual_tick && qual_cnt_ff != cfg_ff.overcurrent_filter_time)
            qual_cnt_ff <= qual_cnt_ff + 4'h1;
        end
        else
        begin
          if (low_on[ph] && !low_prev_ff)
            qual_cnt_ff <= cfg_ff.overcurrent_filter_time;
          else if (qual_tick && blank_busy)
            qual_cnt_ff <= qual_cnt_ff - 4'h1;
        end
      end
    end

    always_comb
    begin
      if (cfg_ff.overcurrent_filter_mode == MODE_DEBOUNCE)
        oc_evt[ph] = oc_cmp[ph] && low_on[ph] &&
                     (qual_cnt_ff == cfg_ff.overcurrent_filter_time);
      else
        oc_evt[ph] = oc_cmp[ph] && !blank_busy &&
                     !(low_on[ph] && !low_prev_ff && cfg_ff.overcurrent_filter_time != 4'h0);
    end
  end

  // ****************************************
  // On-state open load
  // ****************************************
  logic [6:0] on_cnt_ff;
  logic       on_fault_ff;
  logic       on_evt;

  assign on_evt = on_active && below_s && (on_cnt_ff == OPEN_TIMEOUT_TICKS) && !on_fault_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      on_cnt_ff <= 7'h00;
    else if (ce)
    begin
      if (!(on_active && below_s))
        on_cnt_ff <= 7'h00;
      else if (open_tick && on_cnt_ff != OPEN_TIMEOUT_TICKS)
        on_cnt_ff <= on_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      on_fault_ff <= 1'b0;
    else if (ce)
    begin
      if (on_evt)
        on_fault_ff <= 1'b1;
      else if (on_active && !below_s)
        on_fault_ff <= 1'b0;
    end
  end

  // ****************************************
  // Off-state open load
  // ****************************************
  logic [6:0] off_cnt_ff;
  logic       off_fault_ff;
  logic       off_evt;

  assign off_evt = off_active && diff_s && (off_cnt_ff == OPEN_TIMEOUT_TICKS) && !off_fault_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      off_cnt_ff <= 7'h00;
    else if (ce)
    begin
      if (!(off_active && diff_s))
        off_cnt_ff <= 7'h00;
      else if (open_tick && off_cnt_ff != OPEN_TIMEOUT_TICKS)
        off_cnt_ff <= off_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      off_fault_ff <= 1'b0;
    else if (ce)
    begin
      if (off_evt)
        off_fault_ff <= 1'b1;
      else if (!(off_active && diff_s))
        off_fault_ff <= 1'b0;
    end
  end

  // ****************************************
  // Sticky flags and interrupt
  // ****************************************
  bom_flags_t set_evt;
  bom_flags_t nxt_status;

  assign set_evt = {on_evt || off_evt, oc_evt[1], oc_evt[0]};

  always_comb
  begin
    nxt_status = status_ff;
    if (wr_status)
      nxt_status = status_ff & ~bom_flags_t'(reg_wdata[2:0]);
    nxt_status = nxt_status | set_evt;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_ff <= STATUS_RST;
      irq       <= 1'b0;
    end
    else if (ce)
    begin
      status_ff <= nxt_status;
      irq       <= |(nxt_status & mask_ff);
    end
  end

  // ****************************************
  // Analog control outputs
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overcurrent_threshold_code <= 4'h0;
      open_load_threshold_code   <= 4'h0;
      sink_enable                <= 1'b0;
      source_enable              <= 1'b0;
      test_current_select        <= 1'b0;
    end
    else if (ce)
    begin
      overcurrent_threshold_code <= cfg_ff.overcurrent_threshold_code;
      open_load_threshold_code   <= cfg_ff.open_load_threshold_code;
      sink_enable                <= off_active;
      source_enable              <= off_active;
      test_current_select        <= cfg_ff.test_current_select;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (ce)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          ADDR_CONFIG: reg_rdata <= {16'h0000, cfg_ff};
          ADDR_STATUS: reg_rdata <= {29'h0000_0000, status_ff};
          ADDR_MASK:   reg_rdata <= {29'h0000_0000, mask_ff};
          ADDR_LIVE:   reg_rdata <= {28'h000_0000, off_active, on_active, off_fault_ff, on_fault_ff};
          default:     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : bom_monitor
`default_nettype wire

// file: design/bom_pkg.sv
package bom_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned QUAL_STEP_NS     = 500;
  localparam int unsigned QUAL_STEP_CYC    = (QUAL_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OPEN_TICK_US       = 1000;
  localparam int unsigned OPEN_TICK_CYC      = OPEN_TICK_US * CLK_MHZ;
  localparam int unsigned OPEN_TIMEOUT_MS    = 100;
  localparam logic [6:0]  OPEN_TIMEOUT_TICKS = 7'(OPEN_TIMEOUT_MS * 1000 / OPEN_TICK_US);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  ADDR_CONFIG = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_MASK   = 8'h08;
  localparam logic [7:0]  ADDR_LIVE   = 8'h0c;

  localparam logic [15:0] CONFIG_RST  = 16'h0000;
  localparam logic [2:0]  STATUS_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST    = 3'h0;

  localparam logic        MODE_DEBOUNCE = 1'b0;
  localparam logic        MODE_BLANKING = 1'b1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] open_load_threshold_code;
    logic       test_current_select;
    logic       offstate_check_disable;
    logic       onstate_check_enable;
    logic       overcurrent_filter_mode;
    logic [3:0] overcurrent_filter_time;
    logic [3:0] overcurrent_threshold_code;
  } bom_cfg_t;

  typedef struct packed {
    logic open_load_flag;
    logic overcurrent_flag_b;
    logic overcurrent_flag_a;
  } bom_flags_t;

  typedef struct packed {
    logic gate_high_a;
    logic gate_low_a;
    logic gate_high_b;
    logic gate_low_b;
  } bom_gates_t;

endpackage : bom_pkg

// file: design/bom_tick.sv
`timescale 1ns/1ps
`default_nettype none
module bom_tick #(
  parameter int unsigned CYCLES = 125
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ce,
  output logic      tick
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_ff;

  // ****************************************
  // Free running prescaler
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (cnt_ff == LAST);
      if (cnt_ff == LAST)
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + W'(1);
    end
  end
endmodule : bom_tick
`default_nettype wire

// file: dv/bom_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bom_chk
  import bom_pkg::*;
#(
  parameter int unsigned OPEN_TICK_CYCLES = 5
) (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                ce,
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire bom_pkg::bom_gates_t gates,
  input wire logic [3:0]          overcurrent_threshold_code,
  input wire logic [3:0]          open_load_threshold_code,
  input wire logic                sink_enable,
  input wire logic                source_enable,
  input wire logic                test_current_select,
  input wire logic                irq
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic cfg_wr;
  assign cfg_wr = ce && reg_wr && reg_addr == ADDR_CONFIG;

  chk_sink_pair: assert property (sink_enable == source_enable)
    else $error("sink and source differ");
  chk_gates_off: assert property (ce && gates != 4'h0 |=> !sink_enable)
    else $error("sink on with a gate on");
  chk_disable_off: assert property (cfg_wr && reg_wdata[10] ##1 (ce && !reg_wr) |=> !sink_enable)
    else $error("sink on while disabled");
  chk_oc_code: assert property (cfg_wr ##1 ce |=> overcurrent_threshold_code == $past(reg_wdata[3:0], 2))
    else $error("overcurrent code wrong");
  chk_load_code: assert property (cfg_wr ##1 ce |=> open_load_threshold_code == $past(reg_wdata[15:12], 2))
    else $error("open load code wrong");
  chk_tcs_copy: assert property (cfg_wr ##1 ce |=> test_current_select == $past(reg_wdata[11], 2))
    else $error("test current select wrong");
  chk_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read");
  chk_mask_quiet: assert property (ce && reg_wr && reg_addr == ADDR_MASK && reg_wdata[2:0] == 3'h0
    ##1 (ce && !(reg_wr && reg_addr == ADDR_MASK)) |=> !irq)
    else $error("irq while masked");

  cover property (irq);
  cover property ($rose(sink_enable));
  cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : bom_chk

bind bom_monitor bom_chk #(.OPEN_TICK_CYCLES(OPEN_TICK_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gates(gates),
  .overcurrent_threshold_code(overcurrent_threshold_code),
  .open_load_threshold_code(open_load_threshold_code), .sink_enable(sink_enable),
  .source_enable(source_enable), .test_current_select(test_current_select), .irq(irq));
`default_nettype wire

// file: dv/bom_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module bom_load_model (
  input wire bom_pkg::bom_gates_t gates,
  input wire logic                sink_enable,
  input wire logic                source_enable,
  input wire logic                short_a,
  input wire logic                short_b,
  input wire logic                load_open,
  output logic                    oc_cmp_a,
  output logic                    oc_cmp_b,
  output logic                    sense_below_thr,
  output logic                    terminal_diff_high
);
  import bom_pkg::*;
  // ********
  // Bridge and load
  // ********
  logic on_state;
  assign on_state = (gates.gate_high_a && gates.gate_low_b) || (gates.gate_high_b && gates.gate_low_a);
  // Shorted phase current seen only through its low side
  assign oc_cmp_a = short_a && gates.gate_low_a;
  assign oc_cmp_b = short_b && gates.gate_low_b;
  // No load current holds sense_below_thr high
  assign sense_below_thr = on_state ? load_open : 1'b1;
  // Test current lifts terminal A only with no load
  assign terminal_diff_high = sink_enable && source_enable && load_open;
endmodule : bom_load_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bom_pkg::*;
  // ********
  // Signals
  // ********
  logic        clk_sys, sys_rst, ce, reg_wr, reg_rd, short_a, short_b, load_open;
  logic        oc_a, oc_b, below, diff_high, sink_en, src_en, tcs, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  oc_code, open_code;
  bom_gates_t  gates;
  int          fails, check_count;
  int          cyc = 0;

  bom_monitor #(.OPEN_TICK_CYCLES(5)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gates(gates), .oc_cmp_a(oc_a), .oc_cmp_b(oc_b), .sense_below_thr(below), .terminal_diff_high(diff_high),
    .overcurrent_threshold_code(oc_code), .open_load_threshold_code(open_code), .sink_enable(sink_en),
    .source_enable(src_en), .test_current_select(tcs), .irq(irq));
  bom_load_model u_load (.gates(gates), .sink_enable(sink_en), .source_enable(src_en), .short_a(short_a),
    .short_b(short_b), .load_open(load_open), .oc_cmp_a(oc_a), .oc_cmp_b(oc_b), .sense_below_thr(below),
    .terminal_diff_high(diff_high));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  // ********
  // Tests
  // ********
  initial
  begin
    {sys_rst, ce, reg_wr, reg_rd, short_a, short_b, load_open} = 7'h60;
    {reg_addr, reg_wdata, gates, fails, check_count} = '0;
    step(8);
    sys_rst <= 1'b0;
    rdc(ADDR_CONFIG, 32'h0);
    rdc(ADDR_STATUS, 32'h0);
    wr(8'h10, 32'hffff);
    rdc(8'h10, 32'h0);
    rdc(ADDR_MASK, 32'h0);
    wr(ADDR_CONFIG, 32'hb8c5);
    rdc(ADDR_CONFIG, 32'hb8c5);
    chk(oc_code, 4'h5);
    chk(open_code, 4'hb);
    chk(tcs, 1'b1);
    chk(sink_en, 1'b1);
    wr(ADDR_MASK, 32'h7);
    // Off-state open load, left early once
    load_open <= 1'b1;
    step(300);
    gates <= 4'b0001;
    step(10);
    gates <= 4'b0000;
    step(300);
    rdc(ADDR_STATUS, 32'h0);
    step(300);
    rdc(ADDR_STATUS, 32'h4);
    chk(irq, 1'b1);
    rdc(ADDR_LIVE, 32'ha);
    load_open <= 1'b0;
    step(5);
    rdc(ADDR_LIVE, 32'h8);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'h4);
    rdc(ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, 32'h0400);
    load_open <= 1'b1;
    step(600);
    rdc(ADDR_STATUS, 32'h0);
    chk(sink_en, 1'b0);
    // On-state open load
    wr(ADDR_CONFIG, 32'h0600);
    gates <= 4'b1001;
    step(600);
    rdc(ADDR_STATUS, 32'h4);
    rdc(ADDR_LIVE, 32'h5);
    load_open <= 1'b0;
    step(5);
    rdc(ADDR_LIVE, 32'h4);
    rdc(ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'h4);
    wr(ADDR_CONFIG, 32'h0400);
    load_open <= 1'b1;
    step(600);
    rdc(ADDR_STATUS, 32'h0);
    // Debounce on phase A, time code 2
    load_open <= 1'b0;
    wr(ADDR_CONFIG, 32'h0420);
    gates <= 4'b0100;
    short_a <= 1'b1;
    step(100);
    short_a <= 1'b0;
    step(10);
    rdc(ADDR_STATUS, 32'h0);
    short_a <= 1'b1;
    step(500);
    short_a <= 1'b0;
    step(10);
    rdc(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    rdc(ADDR_STATUS, 32'h0);
    // Blanking on phase B, time code 4
    wr(ADDR_CONFIG, 32'h0540);
    short_b <= 1'b1;
    gates <= 4'b0001;
    step(300);
    rdc(ADDR_STATUS, 32'h0);
    step(400);
    rdc(ADDR_STATUS, 32'h2);
    // Frozen clock enable ignores a write
    ce <= 1'b0;
    wr(ADDR_MASK, 32'h0);
    ce <= 1'b1;
    rdc(ADDR_MASK, 32'h7);
    chk(irq, 1'b1);
    results();
  end
endmodule : tb
`default_nettype wire
